// *** logic/stfc_pkg.sv ***
// Purpose: shared constants for the serial tape flow control block
// Assumes: 250 MHz controller clock
// Notes: control codes are the same for both character sets
package stfc_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int MAX_BAUD = 19200;
    localparam int DEF_BAUD = 9600;
    localparam int BAUD_DIV_W = 16;
    localparam logic [BAUD_DIV_W-1:0] DIV_MIN = BAUD_DIV_W'(CLK_HZ / MAX_BAUD);
    localparam logic [BAUD_DIV_W-1:0] DIV_DEF = BAUD_DIV_W'(CLK_HZ / DEF_BAUD);
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 2;
    localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
    localparam logic [7:0] CODE_DC1 = 8'h11;
    localparam logic [7:0] CODE_DC2 = 8'h92;
    localparam logic [7:0] CODE_DC3 = 8'h13;
    localparam logic [7:0] CODE_DC4 = 8'h94;
    localparam logic [3:0] OVERRUN_LIMIT = 4'hA;
    localparam logic [1:0] CS_STOP_CHARS = 2'h2;
    localparam logic [3:0] DC3_STOP_CHARS = 4'hA;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] ALARM_OVERRUN = 8'h57;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_RD_RUN = 3'h1, ST_RD_HOLD = 3'h3, ST_RD_END = 3'h2,
        ST_WR_OPEN = 3'h6, ST_WR_DATA = 3'h7, ST_WR_END = 3'h5
    } stfc_state_t;
endpackage

// *** logic/stfc_fifo_if.sv ***
// Purpose: stream handshake between block and its FIFO
// Assumes: one clock
// Notes: valid/ready pairs on both sides
`timescale 1ns/1ps
`default_nettype none
interface stfc_fifo_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** logic/stfc_fifo.sv ***
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: honest full and empty
`timescale 1ns/1ps
`default_nettype none
module stfc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    stfc_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = port.in_valid && port.in_ready;
    wire pop = port.out_valid && port.out_ready;
    assign port.in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign port.out_valid = (cnt_reg != '0);
    assign port.out_data = mem_reg[rd_reg];
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_reg[wr_reg] <= port.in_data;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_reg + AW'(push);
            rd_reg <= rd_reg + AW'(pop);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// *** logic/stfc_top.sv ***
// Purpose: character flow control on a serial tape link
// Assumes: 250 MHz clock, 8 data bits incl. parity, 2 stop bits
// Notes: output data buffered in a 16-word FIFO
`timescale 1ns/1ps
`default_nettype none
module stfc_top
    import stfc_pkg::*;
#(
    parameter int FIFO_W = DATA_BITS,
    parameter int FIFO_D = FIFO_DEPTH,
    parameter logic [BAUD_DIV_W-1:0] DIV_FLOOR = DIV_MIN
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [stfc_pkg::BAUD_DIV_W-1:0] baud_div_i,
    input wire logic read_start_i,
    input wire logic read_done_i,
    input wire logic rx_busy_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic overrun_o,
    output logic [7:0] alarm_code_o,
    input wire logic write_start_i,
    input wire logic write_last_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic busy_o,
    input wire logic rxd_i,
    input wire logic cts_i,
    output logic txd_o
);
    import stfc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    stfc_state_t st_reg, st_next;
    logic [2:0] rxd_sync_reg;
    logic [1:0] cts_sync_reg;
    wire rxd_s = rxd_sync_reg[1];
    wire cts_s = cts_sync_reg[1];
    wire [BAUD_DIV_W-1:0] div_eff = (baud_div_i < DIV_FLOOR) ? DIV_FLOOR : baud_div_i;
    wire [BAUD_DIV_W-1:0] div_half = {1'b0, div_eff[BAUD_DIV_W-1:1]};

    stfc_fifo_if #(.W(FIFO_W)) fq ();
    stfc_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .port(fq)
    );
    logic last_seen_reg;
    wire in_write = (st_reg == ST_WR_OPEN) || (st_reg == ST_WR_DATA);
    wire in_read = (st_reg == ST_RD_RUN) || (st_reg == ST_RD_HOLD);
    assign fq.in_valid = tx_valid_i && in_write && !last_seen_reg;
    assign fq.in_data = tx_data_i;
    assign tx_ready_o = fq.in_ready && in_write && !last_seen_reg;
    wire wr_take = tx_valid_i && tx_ready_o;

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    logic [BAUD_DIV_W-1:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic rx_act_reg;
    logic rx_pulse_reg;
    logic [7:0] rx_data_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxd_sync_reg <= 3'h7;
            cts_sync_reg <= 2'h0;
        end else begin
            rxd_sync_reg <= {rxd_sync_reg[1:0], rxd_i};
            cts_sync_reg <= {cts_sync_reg[0], cts_i};
        end
    end
    wire rx_tick = rx_act_reg && (rx_cnt_reg == '0);
    wire rx_start = !rx_act_reg && rxd_sync_reg[2] && !rxd_s;
    wire rx_end = rx_tick && (rx_bit_reg == 4'(DATA_BITS + 1));
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_act_reg <= 1'b0;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_sh_reg <= '0;
            rx_pulse_reg <= 1'b0;
            rx_data_reg <= '0;
        end else begin
            rx_pulse_reg <= 1'b0;
            if (rx_start) begin
                rx_act_reg <= 1'b1;
                rx_cnt_reg <= div_half;
                rx_bit_reg <= '0;
            end else if (rx_tick) begin
                rx_cnt_reg <= div_eff - 1'b1;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == '0 && rxd_s) begin
                    rx_act_reg <= 1'b0;
                end else if (rx_bit_reg != '0 && !rx_end) begin
                    rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
                end
                if (rx_end) begin
                    rx_act_reg <= 1'b0;
                    rx_pulse_reg <= rxd_s;
                    rx_data_reg <= rx_sh_reg;
                end
            end else if (rx_act_reg) begin
                rx_cnt_reg <= rx_cnt_reg - 1'b1;
            end
        end
    end
    // One code set for both character sets
    wire rx_is_dc1 = rx_pulse_reg && (rx_data_reg == CODE_DC1);
    wire rx_is_dc3 = rx_pulse_reg && (rx_data_reg == CODE_DC3);

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    logic [BAUD_DIV_W-1:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [10:0] tx_sh_reg;
    logic tx_act_reg;
    logic tx_load;
    logic [7:0] tx_char;
    wire tx_tick = tx_act_reg && (tx_cnt_reg == '0);
    wire tx_done = tx_tick && (tx_bit_reg == 4'(FRAME_BITS - 1));
    wire tx_free = !tx_act_reg || tx_done;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_act_reg <= 1'b0;
            tx_cnt_reg <= '0;
            tx_bit_reg <= '0;
            tx_sh_reg <= '1;
        end else if (tx_load) begin
            tx_sh_reg <= {2'b11, tx_char, 1'b0};
            tx_act_reg <= 1'b1;
            tx_cnt_reg <= div_eff - 1'b1;
            tx_bit_reg <= '0;
        end else if (tx_done) begin
            tx_act_reg <= 1'b0;
            tx_sh_reg <= '1;
        end else if (tx_tick) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_cnt_reg <= div_eff - 1'b1;
            tx_bit_reg <= tx_bit_reg + 4'h1;
        end else if (tx_act_reg) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
        end
    end
    assign txd_o = tx_sh_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Flow control
    logic [3:0] ovr_cnt_reg;
    logic overrun_reg;
    logic held_reg;
    logic dc3_pause_reg;
    // Only codes and clear-to-send gate output
    // Clear-to-send low holds next char; one in flight ends
    // Received DC3 holds next char from the clock after its strobe
    wire out_ok = cts_s && !dc3_pause_reg;
    wire last_pend = last_seen_reg && !fq.out_valid;
    assign fq.out_ready = (st_reg == ST_WR_DATA) && tx_free && out_ok;
    always_comb begin
        st_next = st_reg;
        tx_load = 1'b0;
        tx_char = fq.out_data;
        unique case (st_reg)
            ST_IDLE: begin
                if (read_start_i && tx_free) begin
                    tx_load = 1'b1;
                    tx_char = CODE_DC1;
                    st_next = ST_RD_RUN;
                end else if (write_start_i && tx_free) begin
                    st_next = ST_WR_OPEN;
                end
            end
            ST_RD_RUN: begin
                if (tx_free && read_done_i) begin
                    tx_load = 1'b1;
                    tx_char = CODE_DC3;
                    st_next = ST_RD_END;
                end else if (tx_free && rx_busy_i) begin
                    tx_load = 1'b1;
                    tx_char = CODE_DC3;
                    st_next = ST_RD_HOLD;
                end
            end
            ST_RD_HOLD: begin
                if (tx_free && read_done_i) begin
                    tx_load = 1'b1;
                    tx_char = CODE_DC3;
                    st_next = ST_RD_END;
                end else if (tx_free && !rx_busy_i) begin
                    tx_load = 1'b1;
                    tx_char = CODE_DC1;
                    st_next = ST_RD_RUN;
                end
            end
            ST_RD_END: begin
                if (tx_free) begin
                    st_next = ST_IDLE;
                end
            end
            ST_WR_OPEN: begin
                if (tx_free && out_ok) begin
                    tx_load = 1'b1;
                    tx_char = CODE_DC2;
                    st_next = ST_WR_DATA;
                end
            end
            ST_WR_DATA: begin
                // Data back to back from FIFO
                if (fq.out_valid && fq.out_ready) begin
                    tx_load = 1'b1;
                end else if (last_pend && tx_free && out_ok) begin
                    tx_load = 1'b1;
                    tx_char = CODE_DC4;
                    st_next = ST_WR_END;
                end
            end
            ST_WR_END: begin
                if (tx_free) begin
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end
    wire dc1_sent = tx_load && (tx_char == CODE_DC1) && !in_write;
    wire hold_sent = tx_load && (st_reg == ST_RD_RUN) && (st_next == ST_RD_HOLD);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= ST_IDLE;
            ovr_cnt_reg <= '0;
            overrun_reg <= 1'b0;
            held_reg <= 1'b0;
            dc3_pause_reg <= 1'b0;
            last_seen_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            if (dc1_sent) begin
                ovr_cnt_reg <= '0;
                held_reg <= 1'b0;
            end else if (hold_sent) begin
                ovr_cnt_reg <= '0;
                held_reg <= 1'b1;
            end else if (held_reg && rx_pulse_reg && ovr_cnt_reg != OVERRUN_LIMIT) begin
                ovr_cnt_reg <= ovr_cnt_reg + 4'h1;
            end
            if (held_reg && rx_pulse_reg && in_read && ovr_cnt_reg == OVERRUN_LIMIT) begin
                overrun_reg <= 1'b1;
            end else if (read_start_i && st_reg == ST_IDLE) begin
                overrun_reg <= 1'b0;
            end
            if (!in_write) begin
                dc3_pause_reg <= 1'b0;
            end else if (rx_is_dc3) begin
                dc3_pause_reg <= 1'b1;
            end else if (rx_is_dc1) begin
                dc3_pause_reg <= 1'b0;
            end
            if (st_reg == ST_IDLE) begin
                last_seen_reg <= 1'b0;
            end else if (wr_take && write_last_i) begin
                last_seen_reg <= 1'b1;
            end
        end
    end
    assign overrun_o = overrun_reg;
    assign alarm_code_o = overrun_reg ? ALARM_OVERRUN : 8'h00;
    // Received chars passed on in order, only in ST_RD_RUN and ST_RD_HOLD
    assign rx_valid_o = rx_pulse_reg && in_read;
    assign rx_data_o = rx_data_reg;
    assign busy_o = (st_reg != ST_IDLE);
endmodule
`default_nettype wire

// *** tb/stfc_top_checker.sv ***
// Purpose: port-level checks for stfc_top
// Assumes: one clock, asynchronous active-low reset
// Notes: bound into every stfc_top instance
`timescale 1ns/1ps
`default_nettype none
module stfc_top_checker
    import stfc_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic read_start_i,
    input wire logic write_start_i,
    input wire logic rx_valid_o,
    input wire logic overrun_o,
    input wire logic [7:0] alarm_code_o,
    input wire logic tx_ready_o,
    input wire logic busy_o,
    input wire logic txd_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    sequence rd_take_s;
        !busy_o && read_start_i;
    endsequence
    sequence rd_open_s;
        busy_o && !txd_o ##1 !txd_o;
    endsequence
    read_open_a: assert property (rd_take_s |=> rd_open_s)
        else $error("read did not open with a start bit");
    write_open_a: assert property (!busy_o && write_start_i && !read_start_i |=> busy_o && tx_ready_o)
        else $error("write did not open");
    idle_line_a: assert property (!busy_o |-> txd_o && !tx_ready_o)
        else $error("idle but line or ready active");
    alarm_code_a: assert property (alarm_code_o == (overrun_o ? ALARM_OVERRUN : 8'h00))
        else $error("alarm code does not follow overrun");
    overrun_hold_a: assert property (overrun_o && !(!busy_o && read_start_i) |=> overrun_o)
        else $error("overrun flag lost");
    overrun_read_a: assert property ($rose(overrun_o) |-> busy_o)
        else $error("overrun raised outside a read");
    rx_pulse_a: assert property (rx_valid_o |-> busy_o ##1 !rx_valid_o)
        else $error("receive strobe wrong");
    start_bit_a: assert property ($fell(txd_o) |-> !txd_o [*8])
        else $error("start bit too short");
endmodule
bind stfc_top stfc_top_checker u_chk (.clock_i(clock_i), .resetn_i(resetn_i), .read_start_i(read_start_i),
    .write_start_i(write_start_i), .rx_valid_o(rx_valid_o), .overrun_o(overrun_o), .alarm_code_o(alarm_code_o),
    .tx_ready_o(tx_ready_o), .busy_o(busy_o), .txd_o(txd_o));
`default_nettype wire

// *** tb/stfc_dev_model.sv ***
// Purpose: far-side reader/punch model on the serial line
// Assumes: DIV clocks per bit
// Notes: sends numbered chars between start and stop codes, single control codes on request
`timescale 1ns/1ps
`default_nettype none
module stfc_dev_model
    import stfc_pkg::*;
#(
    parameter int DIV = 13020
) (
    input wire logic clock_i,
    input wire logic txd_i,
    input wire logic cts_en_i,
    input wire logic bad_i,
    input wire logic [7:0] base_i,
    input wire logic [3:0] n_send_i,
    input wire logic ctl_send_i,
    input wire logic [7:0] ctl_byte_i,
    output logic rxd_o,
    output logic cts_o,
    output logic got_o,
    output logic [7:0] got_byte_o
);
    logic go = 1'b0;
    logic [10:0] frame;
    int sent = 0;
    initial rxd_o = 1'b1;
    initial got_o = 1'b0;
    assign cts_o = cts_en_i;
    always begin
        @(negedge txd_i);
        repeat (DIV / 2) @(posedge clock_i);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clock_i);
            got_byte_o[i] = txd_i;
        end
        repeat (DIV) @(posedge clock_i);
        if (got_byte_o == CODE_DC1) go = 1'b1;
        if (got_byte_o == CODE_DC3 && !bad_i) go = 1'b0;
        if (got_byte_o == CODE_DC2 || got_byte_o == CODE_DC4) go = 1'b0;
        got_o <= 1'b1;
        @(posedge clock_i);
        got_o <= 1'b0;
    end
    task automatic send_char(input logic [7:0] c);
        frame = {2'b11, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_o <= frame[i];
            repeat (DIV) @(posedge clock_i);
        end
    endtask
    always begin
        @(posedge clock_i);
        if (ctl_send_i) begin
            send_char(ctl_byte_i);
        end else if (go && sent < int'(n_send_i)) begin
            send_char(base_i + 8'(sent));
            sent++;
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_stfc_top.sv ***
// Purpose: self-checking bench for stfc_top
// Assumes: model runs at the clamped bit rate
// Notes: FIFO shrunk to FD words and divider floor lowered to DIV to shorten the run
`timescale 1ns/1ps
`default_nettype none
module tb_stfc_top;
    import stfc_pkg::*;
    localparam int FD = 4;
    localparam int DIV = 32;
    localparam int FRAME = FRAME_BITS * DIV;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic read_start_i = 1'b0, read_done_i = 1'b0, rx_busy_i = 1'b0, write_start_i = 1'b0;
    logic write_last_i = 1'b0, tx_valid_i = 1'b0, cts_en = 1'b0, bad_dev = 1'b0;
    logic [7:0] tx_data_i = 8'h00, base = 8'h00, rx_data_o, alarm_code_o, got_byte;
    logic [3:0] n_send = 4'h0;
    logic ctl_send = 1'b0;
    logic [7:0] ctl_byte = 8'h00;
    logic rx_valid_o, overrun_o, tx_ready_o, busy_o, rxd_i, cts_i, txd_o, got;
    logic [7:0] txq[$], rxq[$], d[$];
    int errors = 0, cmp_count = 0, cyc = 0, n_tx = 0, n0;
    always #2 clock_i = ~clock_i;
    stfc_top #(.FIFO_D(FD), .DIV_FLOOR(BAUD_DIV_W'(DIV))) u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
        .baud_div_i(16'h0010), .read_start_i(read_start_i), .read_done_i(read_done_i), .rx_busy_i(rx_busy_i),
        .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o), .overrun_o(overrun_o), .alarm_code_o(alarm_code_o),
        .write_start_i(write_start_i), .write_last_i(write_last_i), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .busy_o(busy_o), .rxd_i(rxd_i), .cts_i(cts_i),
        .txd_o(txd_o));
    stfc_dev_model #(.DIV(DIV)) u_dev (.clock_i(clock_i), .txd_i(txd_o), .cts_en_i(cts_en), .bad_i(bad_dev),
        .base_i(base), .n_send_i(n_send), .ctl_send_i(ctl_send), .ctl_byte_i(ctl_byte), .rxd_o(rxd_i),
        .cts_o(cts_i), .got_o(got), .got_byte_o(got_byte));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (got === 1'b1) txq.push_back(got_byte);
        if (got === 1'b1) n_tx++;
        if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
        if (cyc == 80 * FRAME) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic expect_tx(input logic [7:0] e);
        for (int n = 0; n < 3 * FRAME && txq.size() == 0; n++)
            @(posedge clock_i);
        if (txq.size() == 0) txq.push_back(~e);
        chk(txq.pop_front(), e, "line char");
        @(negedge clock_i);
    endtask
    task automatic idle();
        for (int n = 0; n < 2 * FRAME && busy_o !== 1'b0; n++)
            @(negedge clock_i);
        chk(8'(busy_o), 8'h00, "busy");
    endtask
    task automatic push(input logic [7:0] v, input logic l);
        tx_data_i = v;
        write_last_i = l;
        tx_valid_i = 1'b1;
        for (int n = 0; n < 3 * FRAME && tx_ready_o !== 1'b1; n++)
            @(negedge clock_i);
        @(negedge clock_i);
        tx_valid_i = 1'b0;
        write_last_i = 1'b0;
        @(negedge clock_i);
    endtask
    task automatic start_read();
        read_start_i = 1'b1;
        @(negedge clock_i);
        read_start_i = 1'b0;
    endtask
    task automatic ctl(input logic [7:0] c);
        ctl_byte = c;
        ctl_send = 1'b1;
        @(negedge clock_i);
        ctl_send = 1'b0;
        repeat (FRAME + DIV) @(negedge clock_i);
    endtask
    initial begin
        void'($urandom(32'hB04FBC8F));
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        resetn_i = 1'b1;
        base = 8'($urandom);
        n_send = 4'h2;
        start_read();
        expect_tx(CODE_DC1);
        rx_busy_i = 1'b1;
        expect_tx(CODE_DC3);
        rx_busy_i = 1'b0;
        expect_tx(CODE_DC1);
        for (int n = 0; n < 4 * FRAME && rxq.size() < 2; n++)
            @(negedge clock_i);
        for (int k = 0; k < 2; k++)
            chk(rxq.size() > 0 ? rxq.pop_front() : ~(base + 8'(k)), base + 8'(k), "rx char");
        read_done_i = 1'b1;
        expect_tx(CODE_DC3);
        idle();
        read_done_i = 1'b0;
        chk(8'(overrun_o), 8'h00, "overrun");
        $display("test read done");
        write_start_i = 1'b1;
        @(negedge clock_i);
        write_start_i = 1'b0;
        for (int k = 0; k <= FD; k++)
            d.push_back(8'($urandom));
        for (int k = 0; k < FD; k++)
            push(d[k], 1'b0);
        chk(8'(tx_ready_o), 8'h00, "full buffer ready");
        cts_en = 1'b1;
        push(d[FD], 1'b1);
        expect_tx(CODE_DC2);
        expect_tx(d[0]);
        cts_en = 1'b0;
        n0 = n_tx;
        repeat (3 * FRAME) @(negedge clock_i);
        chk(8'(n_tx - n0 <= 2), 8'h01, "chars after send held");
        cts_en = 1'b1;
        for (int k = 1; k <= FD; k++)
            expect_tx(d[k]);
        expect_tx(CODE_DC4);
        idle();
        $display("test write done");
        n_send = 4'hE;
        bad_dev = 1'b1;
        start_read();
        expect_tx(CODE_DC1);
        rx_busy_i = 1'b1;
        expect_tx(CODE_DC3);
        for (int n = 0; n < 14 * FRAME && overrun_o !== 1'b1; n++)
            @(negedge clock_i);
        chk(8'(overrun_o), 8'h01, "overrun");
        chk(alarm_code_o, ALARM_OVERRUN, "alarm code");
        rx_busy_i = 1'b0;
        expect_tx(CODE_DC1);
        read_done_i = 1'b1;
        expect_tx(CODE_DC3);
        idle();
        read_done_i = 1'b0;
        $display("test overrun done");
        cts_en = 1'b0;
        write_start_i = 1'b1;
        @(negedge clock_i);
        write_start_i = 1'b0;
        ctl(CODE_DC3);
        push(d[0], 1'b0);
        push(d[1], 1'b1);
        cts_en = 1'b1;
        n0 = n_tx;
        repeat (2 * FRAME) @(negedge clock_i);
        chk(8'(n_tx - n0), 8'h00, "chars after pause code");
        ctl(CODE_DC1);
        expect_tx(CODE_DC2);
        expect_tx(d[0]);
        expect_tx(d[1]);
        expect_tx(CODE_DC4);
        idle();
        $display("test pause code done");
        report_and_stop();
    end
endmodule
`default_nettype wire
